/* common/scp_pkg.sv */
// Package for the status code panel presenter: code record layout,
// display constants, timing constants and modes.
// Assumes a single 40 MHz system clock.
package scp_pkg;

    // ==================================================
    // Geometry
    localparam int DIGIT_W      = 4;
    localparam int GROUP_CHARS  = 4;
    localparam int GROUP_W      = DIGIT_W * GROUP_CHARS;
    localparam int MAX_FIELDS   = 8;
    localparam int FCNT_W       = 4;
    localparam int OPER_DEPTH   = 10;
    localparam int OPER_IDX_W   = 4;
    localparam int LOG_DEPTH    = 100;
    localparam int LOG_IDX_W    = 7;
    localparam int STEP_W       = 4;

    // Blank character code in each digit position
    localparam logic [DIGIT_W-1:0] BLANK_CHAR  = 4'hF;
    localparam logic [GROUP_W-1:0] BLANK_GROUP = {GROUP_CHARS{BLANK_CHAR}};

    // ==================================================
    // Timing
    localparam longint CLK_HZ         = 40000000;
    localparam longint HOLD_SECONDS   = 3600;
    localparam longint HOLD_CYCLES    = CLK_HZ * HOLD_SECONDS;
    localparam longint SCROLL_MS      = 2000;
    localparam longint SCROLL_CYCLES  = (CLK_HZ / 1000) * SCROLL_MS;
    localparam int     TIMER_W        = 38;

    // ==================================================
    // Code formats
    typedef enum logic [1:0] {
        scp_fmt_plain,
        scp_fmt_fru_list,
        scp_fmt_ext_bytes,
        scp_fmt_type_fru_location_field
    } scp_fmt_type;

    // Base code digits; unused high digits hold BLANK_CHAR
    typedef struct packed {
        scp_fmt_type                       fmt;
        logic [GROUP_W-1:0]                base;
        logic [FCNT_W-1:0]                 nfields;
        logic [MAX_FIELDS-1:0][GROUP_W-1:0] fields;
    } scp_code_type;

    // Incoming code with its routing
    typedef struct packed {
        logic         valid;
        logic         temporary;
        logic         offline;
        scp_code_type code;
    } scp_event_type;

    typedef enum logic [1:0] {
        scp_mode_oper,
        scp_mode_offline_panel,
        scp_mode_offline_term
    } scp_mode_type;

    // Panel output
    typedef struct packed {
        logic               lit;
        logic [GROUP_W-1:0] chars;
    } scp_panel_type;

    // Terminal output: whole record at once
    typedef struct packed {
        logic         valid;
        scp_code_type code;
    } scp_term_type;

endpackage

/* verilog/scp_presenter.sv */
// Status code panel presenter: holds operational and offline codes and
// drives a four-character operator panel and a terminal record stream.
// Assumes key inputs are single-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module scp_presenter (
    // Clock, reset, enable
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  clk_en,
    // Controller side
    input  wire scp_pkg::scp_event_type code_in,
    input  wire logic                  offline_mode,
    input  wire logic                  term_control,
    input  wire logic                  clear_codes,
    // Operator keys
    input  wire logic                  key_advance,
    input  wire logic                  key_enter,
    // Outputs
    output scp_pkg::scp_panel_type     panel,
    output scp_pkg::scp_term_type      term_out,
    output logic [scp_pkg::OPER_IDX_W-1:0] oper_count,
    output logic [scp_pkg::LOG_IDX_W-1:0]  log_count
);

    // ==================================================
    // Storage
    scp_pkg::scp_code_type oper_mem [scp_pkg::OPER_DEPTH];
    scp_pkg::scp_code_type log_mem  [scp_pkg::LOG_DEPTH];

    typedef enum logic [1:0] {
        scp_st_blank,
        scp_st_scroll,
        scp_st_frozen
    } scp_view_type;

    scp_view_type                    view;
    logic [scp_pkg::OPER_IDX_W-1:0]  cur_oper;
    logic [scp_pkg::LOG_IDX_W-1:0]   cur_log;
    logic [scp_pkg::STEP_W-1:0]      step;
    logic                            scroll_gap;
    logic [scp_pkg::TIMER_W-1:0]     hour_cnt;
    logic [scp_pkg::TIMER_W-1:0]     scroll_cnt;

    // ==================================================
    // Event decode
    // Temporary failures go to the event log elsewhere, never here
    wire accept    = code_in.valid & ~code_in.temporary;
    wire store_op  = accept & ~code_in.offline &
                     (oper_count < scp_pkg::OPER_IDX_W'(scp_pkg::OPER_DEPTH));
    wire store_log = accept & code_in.offline &
                     (log_count < scp_pkg::LOG_IDX_W'(scp_pkg::LOG_DEPTH));
    wire to_term   = accept & code_in.offline & term_control;

    wire panel_off = offline_mode & ~term_control;
    wire multi     = oper_count > scp_pkg::OPER_IDX_W'(1);

    wire hour_done = hour_cnt >= scp_pkg::TIMER_W'(scp_pkg::HOLD_CYCLES - 1);
    wire tick      = scroll_cnt >= scp_pkg::TIMER_W'(scp_pkg::SCROLL_CYCLES - 1);

    // ==================================================
    // Current record and step decode
    scp_pkg::scp_code_type cur_code;
    assign cur_code = panel_off ? log_mem[cur_log] : oper_mem[cur_oper];

    // Step 0 is base, 1..nfields fields, then blank groups
    // Plain codes carry no fields; type/location codes carry one pair only
    wire fmt_plain = (cur_code.fmt == scp_pkg::scp_fmt_plain);
    wire fmt_pair  = (cur_code.fmt == scp_pkg::scp_fmt_type_fru_location_field);
    // Clamp guards the field index against a corrupt count
    wire [scp_pkg::STEP_W-1:0] nf_raw = scp_pkg::STEP_W'(cur_code.nfields);
    wire [scp_pkg::STEP_W-1:0] nf_max = scp_pkg::STEP_W'(scp_pkg::MAX_FIELDS);
    wire [scp_pkg::STEP_W-1:0] nf_two = scp_pkg::STEP_W'(2);
    wire [scp_pkg::STEP_W-1:0] nf =
        fmt_plain                  ? '0     :
        (fmt_pair && nf_raw > nf_two) ? nf_two :
        (nf_raw > nf_max)          ? nf_max :
                                     nf_raw;
    wire last_log  = (cur_log == log_count - scp_pkg::LOG_IDX_W'(1));
    wire in_field  = (step != '0) && (step <= nf);
    // Operational: two blanks after fields; offline: one, two at list end
    wire [scp_pkg::STEP_W-1:0] nblank =
        (panel_off && !last_log) ? scp_pkg::STEP_W'(1) : scp_pkg::STEP_W'(2);
    wire step_last = (step == nf + nblank);

    wire [scp_pkg::FCNT_W-1:0] fidx = scp_pkg::FCNT_W'(step - scp_pkg::STEP_W'(1));
    wire [scp_pkg::GROUP_W-1:0] shown =
        (step == '0) ? cur_code.base :
        in_field     ? cur_code.fields[fidx[2:0]] :
                       scp_pkg::BLANK_GROUP;

    // Formats differ only in field count and meaning; all are walked alike

    wire have_panel = panel_off ? (log_count != '0) : (oper_count != '0);
    wire show_now   = have_panel &&
                      (panel_off || (view == scp_st_frozen) ||
                       (view == scp_st_scroll && !scroll_gap));

    // ==================================================
    // Code capture
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            oper_count <= '0;
            log_count  <= '0;
        end
        else if (clk_en)
        begin
            if (clear_codes)
            begin
                oper_count <= '0;
                log_count  <= '0;
            end
            else
            begin
                if (store_op)
                    oper_count <= oper_count + scp_pkg::OPER_IDX_W'(1);
                if (store_log)
                    log_count <= log_count + scp_pkg::LOG_IDX_W'(1);
            end
        end
    end

    // Arrays carry no reset; counts qualify their contents
    always_ff @(posedge core_clk)
    begin
        if (clk_en && store_op)
            oper_mem[oper_count] <= code_in.code;
        if (clk_en && store_log)
            log_mem[log_count] <= code_in.code;
    end

    // ==================================================
    // Operational view, timers and offline stepping
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            view       <= scp_st_blank;
            cur_oper   <= '0;
            cur_log    <= '0;
            step       <= '0;
            scroll_gap <= 1'b0;
            hour_cnt   <= '0;
            scroll_cnt <= '0;
        end
        else if (clk_en)
        begin
            if (clear_codes)
            begin
                view     <= scp_st_blank;
                cur_oper <= '0;
                cur_log  <= '0;
                step     <= '0;
            end
            else if (panel_off)
            begin
                if (key_advance && have_panel)
                begin
                    if (!step_last)
                        step <= step + scp_pkg::STEP_W'(1);
                    else
                    begin
                        step    <= '0;
                        cur_log <= last_log ? '0 : cur_log + scp_pkg::LOG_IDX_W'(1);
                    end
                end
            end
            else if (store_op || (key_enter && oper_count != '0))
            begin
                // New code or Enter restarts the hour and the display
                view       <= scp_st_scroll;
                hour_cnt   <= '0;
                scroll_cnt <= '0;
                scroll_gap <= 1'b0;
                step       <= '0;
                if (view == scp_st_blank || store_op)
                    cur_oper <= '0;
            end
            else
            begin
                unique case (view)
                    scp_st_blank:
                        step <= '0;
                    scp_st_scroll:
                    begin
                        hour_cnt <= hour_cnt + scp_pkg::TIMER_W'(1);
                        if (hour_done)
                            view <= scp_st_blank;
                        else if (key_advance && !scroll_gap)
                        begin
                            view <= scp_st_frozen;
                            step <= '0;
                        end
                        else if (multi && tick)
                        begin
                            scroll_cnt <= '0;
                            if (scroll_gap)
                            begin
                                scroll_gap <= 1'b0;
                                cur_oper   <= '0;
                            end
                            else if (cur_oper == oper_count - scp_pkg::OPER_IDX_W'(1))
                                scroll_gap <= 1'b1;
                            else
                                cur_oper <= cur_oper + scp_pkg::OPER_IDX_W'(1);
                        end
                        else if (multi)
                            scroll_cnt <= scroll_cnt + scp_pkg::TIMER_W'(1);
                    end
                    scp_st_frozen:
                        // Hold while frozen: the operator is reading fields
                        if (key_advance)
                            step <= step_last ? '0 : step + scp_pkg::STEP_W'(1);
                    default:
                        view <= scp_st_blank;
                endcase
            end
        end
    end

    // ==================================================
    // Registered outputs
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            panel    <= '{lit: 1'b0, chars: scp_pkg::BLANK_GROUP};
            term_out <= '0;
        end
        else if (clk_en)
        begin
            panel.lit   <= show_now;
            panel.chars <= show_now ? shown : scp_pkg::BLANK_GROUP;
            term_out.valid <= to_term;
            term_out.code  <= to_term ? code_in.code : term_out.code;
        end
    end

endmodule

`default_nettype wire

/* test/scp_presenter_properties.sv */
// Port checker for the status code panel presenter.
// Assumes clear_codes never coincides with a code arrival.
`timescale 1ns/1ps
`default_nettype none

module scp_presenter_properties (
    // Clock and reset
    input wire logic                           core_clk,
    input wire logic                           nrst,
    input wire logic                           clk_en,
    // Controller side and keys
    input wire scp_pkg::scp_event_type         code_in,
    input wire logic                           offline_mode,
    input wire logic                           term_control,
    input wire logic                           clear_codes,
    input wire logic                           key_advance,
    input wire logic                           key_enter,
    // Outputs
    input wire scp_pkg::scp_panel_type         panel,
    input wire scp_pkg::scp_term_type          term_out,
    input wire logic [scp_pkg::OPER_IDX_W-1:0] oper_count,
    input wire logic [scp_pkg::LOG_IDX_W-1:0]  log_count
);
    // ==================================================
    // Properties
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire take = code_in.valid && !code_in.temporary && clk_en && !clear_codes;

    a_reset_blank: assert property (disable iff (1'b0) !nrst && clk_en |=>
        !panel.lit && panel.chars == scp_pkg::BLANK_GROUP && oper_count == 4'h0)
        else $error("panel or count not cleared by reset");
    a_oper_cap: assert property (oper_count <= 4'hA)
        else $error("operational count above ten");
    a_log_cap: assert property (log_count <= 7'h64)
        else $error("log count above one hundred");
    a_temp_dropped: assert property (code_in.valid && code_in.temporary && clk_en |=>
        $stable(oper_count) && $stable(log_count) && !term_out.valid)
        else $error("temporary code was taken");
    a_oper_store: assert property (take && !code_in.offline && oper_count < 4'hA |=>
        oper_count == $past(oper_count) + 4'h1) else $error("operational code not stored");
    a_log_store: assert property (take && code_in.offline && log_count < 7'h64 |=>
        log_count == $past(log_count) + 7'h1) else $error("offline code not stored");
    a_term_emit: assert property (take && code_in.offline && term_control |=>
        term_out.valid && term_out.code == $past(code_in.code)) else $error("terminal miss");
    a_term_cause: assert property (term_out.valid |->
        $past(take && code_in.offline && term_control)) else $error("stray terminal record");
    a_clear_empty: assert property (clear_codes && clk_en |=>
        oper_count == 4'h0 && log_count == 7'h0) else $error("clear left codes");
    a_hold_frozen: assert property (!clk_en |=> $stable(oper_count) && $stable(panel))
        else $error("state moved with clock enable low");

    c_oper: cover property (take && !code_in.offline);
    c_advance: cover property (key_advance && panel.lit);
    c_term: cover property (term_out.valid);
endmodule

bind scp_presenter scp_presenter_properties chk (.core_clk(core_clk), .nrst(nrst),
    .clk_en(clk_en), .code_in(code_in), .offline_mode(offline_mode),
    .term_control(term_control), .clear_codes(clear_codes), .key_advance(key_advance),
    .key_enter(key_enter), .panel(panel), .term_out(term_out),
    .oper_count(oper_count), .log_count(log_count));

`default_nettype wire

/* test/scp_operator.sv */
// Operator at the panel keys: single-cycle Advance and Enter presses.
// Assumes the caller waits for the panel after each press.
`timescale 1ns/1ps
`default_nettype none

module scp_operator (
    // Clock
    input wire logic core_clk,
    // Keys
    output logic     key_advance,
    output logic     key_enter
);
    initial
    begin
        key_advance = 1'b0;
        key_enter = 1'b0;
    end

    // Key pulse lasts one cycle, as the panel expects
    task automatic press(input logic enter);
        @(posedge core_clk);
        key_advance <= !enter;
        key_enter <= enter;
        @(posedge core_clk);
        key_advance <= 1'b0;
        key_enter <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* test/test_status_code_panel_presenter.sv */
// Self-checking bench for the status code panel presenter.
// Assumes the hour and scroll timers never expire within the run.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("unexpected at %0t: got %h expected %h", $time, a, b); \
        end \
    end

module test_status_code_panel_presenter;
    logic                  core_clk = 1'b0;
    logic                  nrst;
    logic                  clk_en;
    logic                  offline_mode;
    logic                  term_control;
    logic                  clear_codes;
    wire logic             key_advance;
    wire logic             key_enter;
    scp_pkg::scp_event_type code_in;
    scp_pkg::scp_panel_type panel;
    scp_pkg::scp_term_type  term_out;
    logic [3:0]            oper_count;
    logic [6:0]            log_count;
    int                    errors;
    int                    checked;
    logic [31:0]           seed;
    scp_pkg::scp_code_type cs [2];
    logic [15:0]           q [$];

    always #12.5 core_clk = ~core_clk;

    scp_presenter uut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .code_in(code_in),
        .offline_mode(offline_mode), .term_control(term_control), .clear_codes(clear_codes),
        .key_advance(key_advance), .key_enter(key_enter), .panel(panel),
        .term_out(term_out), .oper_count(oper_count), .log_count(log_count));
    scp_operator op (.core_clk(core_clk), .key_advance(key_advance), .key_enter(key_enter));

    // ==================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic scp_pkg::scp_code_type mk(input logic [1:0] f, input int nf);
        scp_pkg::scp_code_type c;
        c = '0;
        seed = lfsr(seed);
        c.fmt = scp_pkg::scp_fmt_type'(f);
        c.base = {4'h3, seed[11:0] & 12'h777};
        c.nfields = nf[3:0];
        for (int i = 0; i < nf; i++)
        begin
            seed = lfsr(seed);
            c.fields[i] = seed[15:0] & 16'h7777;
        end
        return c;
    endfunction

    task automatic send(input scp_pkg::scp_code_type c, input logic tmp, input logic off);
        @(posedge core_clk);
        code_in <= {1'b1, tmp, off, c};
        @(posedge core_clk);
        code_in.valid <= 1'b0;
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic clr();
        @(posedge core_clk);
        clear_codes <= 1'b1;
        @(posedge core_clk);
        clear_codes <= 1'b0;
        settle();
    endtask

    // Base, fields, blank per code, extra blank, then first base
    task automatic walk(input int n);
        q = {};
        for (int k = 0; k < n; k++)
        begin
            q.push_back(cs[k].base);
            for (int i = 0; i < cs[k].nfields; i++)
                q.push_back(cs[k].fields[i]);
            q.push_back(scp_pkg::BLANK_GROUP);
        end
        q.push_back(scp_pkg::BLANK_GROUP);
        q.push_back(cs[0].base);
        for (int i = 0; i < q.size(); i++)
        begin
            if (i > 0)
                op.press(1'b0);
            settle();
            `CHK(panel.chars, q[i])
        end
    endtask

    task automatic results();
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==================================================
    // Sequence
    initial
    begin
        repeat (60000) @(posedge core_clk);
        errors++;
        results();
    end

    initial
    begin
        {nrst, offline_mode, term_control, clear_codes} = 4'h0;
        clk_en = 1'b1;
        code_in = '0;
        errors = 0;
        checked = 0;
        seed = 32'h6FEE1805;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        `CHK(panel, {1'b0, scp_pkg::BLANK_GROUP})
        cs[0] = mk(2'h2, 3);
        cs[0].base[15:12] = 4'hF;
        send(cs[0], 1'b1, 1'b0);
        `CHK(oper_count, 4'h0)
        send(cs[0], 1'b0, 1'b0);
        `CHK(oper_count, 4'h1)
        op.press(1'b0);
        walk(1);
        op.press(1'b0);
        op.press(1'b1);
        settle();
        `CHK(panel.chars, cs[0].base)
        @(posedge core_clk);
        clk_en <= 1'b0;
        @(posedge core_clk);
        clk_en <= 1'b1;
        for (int i = 0; i < 11; i++)
            send(mk(i[1:0], i % 9), 1'b0, 1'b0);
        `CHK(oper_count, 4'hA)
        settle();
        `CHK(panel.chars, cs[0].base)
        clr();
        `CHK({oper_count, panel.chars}, {4'h0, scp_pkg::BLANK_GROUP})
        offline_mode <= 1'b1;
        term_control <= 1'b1;
        cs[1] = mk(2'h1, 4);
        send(cs[1], 1'b0, 1'b1);
        `CHK(term_out, {1'b1, cs[1]})
        `CHK(log_count, 7'h1)
        clr();
        term_control <= 1'b0;
        cs[0] = mk(2'h3, 2);
        cs[1] = mk(2'h0, 0);
        send(cs[0], 1'b0, 1'b1);
        send(cs[1], 1'b0, 1'b1);
        `CHK({term_out.valid, log_count}, {1'b0, 7'h2})
        walk(2);
        results();
    end
endmodule

`default_nettype wire
